// ===== rtl/tsc_top.sv
`timescale 1ns/10ps
module tsc_top #(
  parameter int unsigned SUB_DIV    = tsc_pkg::SUB_CYCLES,
  parameter int unsigned SUBS_SEC   = tsc_pkg::SUBS_PER_SEC,
  parameter int unsigned FAST_DIV   = tsc_pkg::FAST_SUBS,
  parameter int unsigned BURST_LEN  = tsc_pkg::BURST_SUBS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ignition_input,
  input  wire logic             motion_in,
  input  wire logic             usb_attached,
  input  wire logic             time_synced,
  input  wire logic             gps_fix,
  input  wire logic [15:0]      step_distance,
  input  wire logic [15:0]      heading_change,
  input  wire logic             event_in,
  input  wire logic             modem_activity,
  input  wire logic             boot_mode,
  input  wire logic             fw_flashing,
  input  wire logic             device_working,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wr_data,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic [31:0]           rd_data,
  output logic                  irq,
  output logic                  gps_power,
  output logic                  gps_sleep,
  output logic                  modem_power,
  output logic                  nav_led,
  output logic                  stat_led,
  output tsc_pkg::tsc_mode_t    mode,
  output logic                  record_strobe,
  output tsc_pkg::tsc_rec_t     record_info
);
  if (SUB_DIV < 2 || SUBS_SEC < 2 || SUBS_SEC > 255 || FAST_DIV < 1 || FAST_DIV > 255
      || BURST_LEN < 1 || BURST_LEN > 255) begin : g_bad
    $error("tsc_top: parameter out of range");
  end

  // ==========================================================
  // reset and input synchronisers
  logic [1:0] rst_pipe_ff;
  logic       rst_sn;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_pipe_ff <= 2'h0;
    else        rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
  end
  assign rst_sn = rst_pipe_ff[1];

  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {ignition_input, motion_in, usb_attached};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  logic ign_s;
  logic mot_s;
  logic usb_s;
  assign ign_s = pin_sync_ff[2];
  assign mot_s = pin_sync_ff[1];
  assign usb_s = pin_sync_ff[0];

  // ==========================================================
  // dividers
  logic [31:0] div_ff;
  logic [7:0]  sub_cnt_ff;
  logic        sec_phase_ff;
  logic        sub_tick;
  logic        sec_tick;
  assign sub_tick = (div_ff == 32'(SUB_DIV - 1));
  assign sec_tick = sub_tick && (sub_cnt_ff == 8'(SUBS_SEC - 1));
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      div_ff       <= 32'h0;
      sub_cnt_ff   <= 8'h0;
      sec_phase_ff <= 1'b0;
    end else begin
      div_ff <= sub_tick ? 32'h0 : div_ff + 32'h1;
      if (sub_tick) sub_cnt_ff <= sec_tick ? 8'h0 : sub_cnt_ff + 8'h1;
      if (sec_tick) sec_phase_ff <= ~sec_phase_ff;
    end
  end

  // ==========================================================
  // registers
  tsc_pkg::tsc_cfg_t cfg_ff;
  logic [tsc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [tsc_pkg::IRQ_W-1:0] irq_en_ff;
  logic [tsc_pkg::IRQ_W-1:0] irq_set;
  logic [tsc_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]               odo_ff;
  logic [15:0]               stop_secs_ff;
  tsc_pkg::tsc_mode_t        mode_ff;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      cfg_ff.ctrl     <= tsc_pkg::CTRL_RST;
      cfg_ff.sleep_to <= tsc_pkg::SLEEP_TO_RST;
      cfg_ff.link_to  <= tsc_pkg::LINK_TO_RST;
      cfg_ff.min_rec  <= tsc_pkg::MIN_REC_RST;
      cfg_ff.send_per <= tsc_pkg::SEND_PER_RST;
      cfg_ff.dist_thr <= tsc_pkg::DIST_THR_RST;
      cfg_ff.ang_thr  <= tsc_pkg::ANG_THR_RST;
      irq_en_ff       <= '0;
    end else if (wr_en) begin
      unique case (addr)
        tsc_pkg::ADR_CTRL:     cfg_ff.ctrl     <= wr_data[1:0];
        tsc_pkg::ADR_SLEEP_TO: cfg_ff.sleep_to <= wr_data[15:0];
        tsc_pkg::ADR_LINK_TO:  cfg_ff.link_to  <= wr_data[15:0];
        tsc_pkg::ADR_MIN_REC:  cfg_ff.min_rec  <= wr_data[15:0];
        tsc_pkg::ADR_SEND_PER: cfg_ff.send_per <= wr_data[15:0];
        tsc_pkg::ADR_DIST_THR: cfg_ff.dist_thr <= wr_data[15:0];
        tsc_pkg::ADR_ANG_THR:  cfg_ff.ang_thr  <= wr_data[15:0];
        tsc_pkg::ADR_IRQ_EN:   irq_en_ff       <= wr_data[tsc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign irq_clr = (wr_en && addr == tsc_pkg::ADR_IRQ_CLR) ? wr_data[tsc_pkg::IRQ_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) irq_stat_ff <= '0;
    else         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) irq <= 1'b0;
    else         irq <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
  end

  logic [31:0] nxt_rd_data;
  always_comb begin
    nxt_rd_data = 32'h0;
    unique case (addr)
      tsc_pkg::ADR_CTRL:     nxt_rd_data = {30'h0, cfg_ff.ctrl};
      tsc_pkg::ADR_SLEEP_TO: nxt_rd_data = {16'h0, cfg_ff.sleep_to};
      tsc_pkg::ADR_LINK_TO:  nxt_rd_data = {16'h0, cfg_ff.link_to};
      tsc_pkg::ADR_MIN_REC:  nxt_rd_data = {16'h0, cfg_ff.min_rec};
      tsc_pkg::ADR_SEND_PER: nxt_rd_data = {16'h0, cfg_ff.send_per};
      tsc_pkg::ADR_DIST_THR: nxt_rd_data = {16'h0, cfg_ff.dist_thr};
      tsc_pkg::ADR_ANG_THR:  nxt_rd_data = {16'h0, cfg_ff.ang_thr};
      tsc_pkg::ADR_STATUS:   nxt_rd_data = {stop_secs_ff, 10'h0, modem_power, gps_power,
                                            stat_led, nav_led, mode_ff};
      tsc_pkg::ADR_ODO:      nxt_rd_data = odo_ff;
      tsc_pkg::ADR_IRQ_STAT: nxt_rd_data = {28'h0, irq_stat_ff};
      tsc_pkg::ADR_IRQ_EN:   nxt_rd_data = {28'h0, irq_en_ff};
      default:               nxt_rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)    rd_data <= 32'h0;
    else if (rd_en) rd_data <= nxt_rd_data;
    else            rd_data <= 32'h0;
  end

  // ==========================================================
  // sleep state machine
  logic        wake_s;
  logic        base_ok;
  logic [16:0] guard_sum;
  logic        periods_ok;
  logic        sleep_ok;
  logic        deep_ok;
  assign wake_s     = mot_s || ign_s || usb_s;
  assign base_ok    = (stop_secs_ff >= cfg_ff.sleep_to) && time_synced && !wake_s;
  assign guard_sum  = {1'b0, cfg_ff.sleep_to} + {1'b0, cfg_ff.link_to};
  assign periods_ok = ({1'b0, cfg_ff.min_rec} > guard_sum) && ({1'b0, cfg_ff.send_per} > guard_sum);
  assign sleep_ok   = cfg_ff.ctrl[tsc_pkg::CTRL_SLEEP_BIT] && base_ok;
  assign deep_ok    = cfg_ff.ctrl[tsc_pkg::CTRL_DEEP_BIT] && base_ok && periods_ok;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)                    stop_secs_ff <= 16'h0;
    else if (wake_s)                stop_secs_ff <= 16'h0;
    else if (sec_tick && mode_ff == tsc_pkg::TSC_AWAKE && stop_secs_ff != 16'hffff)
                                    stop_secs_ff <= stop_secs_ff + 16'h1;
  end

  tsc_pkg::tsc_mode_t nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      tsc_pkg::TSC_AWAKE: begin
        if (deep_ok)       nxt_mode = tsc_pkg::TSC_DEEP;
        else if (sleep_ok) nxt_mode = tsc_pkg::TSC_SLEEP;
      end
      tsc_pkg::TSC_SLEEP: if (wake_s) nxt_mode = tsc_pkg::TSC_AWAKE;
      tsc_pkg::TSC_DEEP:  if (wake_s) nxt_mode = tsc_pkg::TSC_AWAKE;
      default:            nxt_mode = tsc_pkg::TSC_AWAKE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) mode_ff <= tsc_pkg::TSC_AWAKE;
    else         mode_ff <= nxt_mode;
  end
  assign mode = mode_ff;

  // ==========================================================
  // distance accumulator and record triggers
  logic [15:0] per_secs_ff;
  logic [31:0] nxt_sum;
  logic        trig_time;
  logic        trig_dist;
  logic        trig_ang;
  logic        rec_now;
  assign nxt_sum   = odo_ff + ((sec_tick && mot_s) ? {16'h0, step_distance} : 32'h0);
  assign trig_time = sec_tick && mode_ff != tsc_pkg::TSC_SLEEP && (per_secs_ff + 16'h1 >= cfg_ff.min_rec);
  assign trig_dist = sec_tick && mode_ff == tsc_pkg::TSC_AWAKE && cfg_ff.dist_thr != 16'h0
                     && nxt_sum >= {16'h0, cfg_ff.dist_thr};
  assign trig_ang  = sec_tick && mode_ff == tsc_pkg::TSC_AWAKE && cfg_ff.ang_thr != 16'h0
                     && heading_change >= cfg_ff.ang_thr;
  assign rec_now   = trig_time || trig_dist || trig_ang || event_in;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)      odo_ff <= 32'h0;
    else if (rec_now) odo_ff <= 32'h0;
    else              odo_ff <= nxt_sum;
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)                          per_secs_ff <= 16'h0;
    else if (trig_time || trig_dist || trig_ang) per_secs_ff <= 16'h0;
    else if (sec_tick && per_secs_ff != 16'hffff) per_secs_ff <= per_secs_ff + 16'h1;
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      record_strobe <= 1'b0;
      record_info   <= '0;
    end else begin
      record_strobe <= rec_now;
      if (rec_now) begin
        record_info.distance   <= nxt_sum;
        record_info.reduced    <= (mode_ff == tsc_pkg::TSC_DEEP);
        record_info.hold_coord <= !gps_fix || mode_ff != tsc_pkg::TSC_AWAKE;
        record_info.periodic   <= trig_time || trig_dist || trig_ang;
        record_info.cause      <= {trig_ang, trig_dist, trig_time};
      end
    end
  end

  assign irq_set = {rec_now,
                    wake_s && mode_ff != tsc_pkg::TSC_AWAKE,
                    nxt_mode == tsc_pkg::TSC_DEEP && mode_ff == tsc_pkg::TSC_AWAKE,
                    nxt_mode == tsc_pkg::TSC_SLEEP && mode_ff == tsc_pkg::TSC_AWAKE};

  // ==========================================================
  // power gating
  logic [7:0] tx_secs_ff;
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)                                        tx_secs_ff <= 8'h0;
    else if (mode_ff != tsc_pkg::TSC_DEEP)              tx_secs_ff <= 8'h0;
    else if (rec_now)                                   tx_secs_ff <= tsc_pkg::MODEM_TX_S;
    else if (sec_tick && tx_secs_ff != 8'h0)            tx_secs_ff <= tx_secs_ff - 8'h1;
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      gps_power   <= 1'b1;
      gps_sleep   <= 1'b0;
      modem_power <= 1'b1;
    end else begin
      gps_power   <= (mode_ff == tsc_pkg::TSC_AWAKE);
      gps_sleep   <= (mode_ff == tsc_pkg::TSC_DEEP);
      modem_power <= (mode_ff != tsc_pkg::TSC_DEEP) || (tx_secs_ff != 8'h0);
    end
  end

  // ==========================================================
  // indicators
  logic [7:0] fast_cnt_ff;
  logic       fast_ff;
  logic [7:0] burst_ff;
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      fast_cnt_ff <= 8'h0;
      fast_ff     <= 1'b0;
    end else if (sub_tick) begin
      if (fast_cnt_ff == 8'(FAST_DIV - 1)) begin
        fast_cnt_ff <= 8'h0;
        fast_ff     <= ~fast_ff;
      end else begin
        fast_cnt_ff <= fast_cnt_ff + 8'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn)              burst_ff <= 8'h0;
    else if (modem_activity)  burst_ff <= 8'(BURST_LEN);
    else if (sub_tick && burst_ff != 8'h0) burst_ff <= burst_ff - 8'h1;
  end

  logic first_sub;
  assign first_sub = (sub_cnt_ff == 8'h0);
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      nav_led  <= 1'b0;
      stat_led <= 1'b0;
    end else begin
      if (!gps_power || mode_ff == tsc_pkg::TSC_DEEP) nav_led <= 1'b0;
      else if (!gps_fix)                               nav_led <= 1'b1;
      else                                             nav_led <= first_sub;
      if (!device_working || fw_flashing)              stat_led <= 1'b0;
      else if (boot_mode || burst_ff != 8'h0)          stat_led <= fast_ff;
      else if (mode_ff == tsc_pkg::TSC_DEEP)           stat_led <= first_sub && !sec_phase_ff;
      else                                             stat_led <= first_sub;
    end
  end

  // ==========================================================
  // checks
  sequence s_wake_in_sleep;
    mode_ff != tsc_pkg::TSC_AWAKE && wake_s;
  endsequence

  chk_wake_exit: assert property (@(posedge clk) disable iff (!rst_sn)
    s_wake_in_sleep |=> mode_ff == tsc_pkg::TSC_AWAKE)
    else $error("no return to awake on wake condition");

  chk_timer_clear: assert property (@(posedge clk) disable iff (!rst_sn)
    wake_s |=> stop_secs_ff == 16'h0)
    else $error("timeout counter not cleared on wake");

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_sn)
    (mode_ff == tsc_pkg::TSC_AWAKE ##1 mode_ff == tsc_pkg::TSC_SLEEP)
    |-> $past(sleep_ok) && !$past(wake_s))
    else $error("sleep entered without all conditions");

  chk_deep_entry: assert property (@(posedge clk) disable iff (!rst_sn)
    $rose(mode_ff == tsc_pkg::TSC_DEEP) |-> $past(periods_ok) && $past(base_ok))
    else $error("deep sleep entered with short periods");

  chk_gps_off: assert property (@(posedge clk) disable iff (!rst_sn)
    (mode_ff == tsc_pkg::TSC_SLEEP) [*2] |-> !gps_power)
    else $error("receiver powered in sleep");

  chk_modem_deep: assert property (@(posedge clk) disable iff (!rst_sn)
    (mode_ff == tsc_pkg::TSC_DEEP && tx_secs_ff == 8'h0) ##1 mode_ff == tsc_pkg::TSC_DEEP
    |-> !modem_power && gps_sleep)
    else $error("modem powered in deep sleep while idle");

  chk_odo_clear: assert property (@(posedge clk) disable iff (!rst_sn)
    rec_now |=> odo_ff == 32'h0 && record_info.distance == $past(nxt_sum) && record_strobe)
    else $error("record distance or accumulator clear wrong");

  chk_odo_add: assert property (@(posedge clk) disable iff (!rst_sn)
    (sec_tick && mot_s && !rec_now) |=> odo_ff == $past(odo_ff) + {16'h0, $past(step_distance)})
    else $error("accumulator missed a step");

  chk_reduced_rec: assert property (@(posedge clk) disable iff (!rst_sn)
    record_strobe |-> record_info.reduced == ($past(mode_ff) == tsc_pkg::TSC_DEEP))
    else $error("reduced flag wrong");

  chk_nav_dark: assert property (@(posedge clk) disable iff (!rst_sn)
    (mode_ff == tsc_pkg::TSC_DEEP) [*2] |-> !nav_led)
    else $error("navigation light lit in deep sleep");

  chk_stat_dark: assert property (@(posedge clk) disable iff (!rst_sn)
    (!device_working || fw_flashing) |=> !stat_led)
    else $error("status light lit while halted");

  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_sn)
    ##1 irq == |(irq_stat_ff & $past(irq_en_ff)))
    else $error("interrupt output does not follow status");
endmodule : tsc_top

// ===== include/tsc_pkg.sv
// How it works
// - navigation light: lit no fix, blink, dark
// - status light blinks 1 s, deep 2 s
// - fast burst on modem activity, constant boot
// - status light dark when halted or flashing
// - timeout counts only while stationary
// - sleep needs every entry condition at once
// - sleep: receiver off, event records only
// - motion, ignition or usb ends sleep
// - deep: receiver asleep, modem only for sending
// - deep entry also needs both periods long enough
// - motion, ignition or usb ends deep sleep
// - deep records carry the reduced field set
// - add per-second step while moving
// - record takes distance then accumulator clears
// - no fix keeps last coordinate in records
// - records by time, distance or heading
package tsc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SUB_PERIOD_MS  = 100;
  localparam int unsigned SUB_CYCLES     = CLK_HZ / 1000 * SUB_PERIOD_MS;
  localparam int unsigned SUBS_PER_SEC   = 1000 / SUB_PERIOD_MS;
  localparam int unsigned FAST_SUBS      = 1;
  localparam int unsigned BURST_SUBS     = 8;
  localparam logic [7:0]  MODEM_TX_S     = 8'h0a;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADR_CTRL        = 8'h00;
  localparam logic [7:0] ADR_SLEEP_TO    = 8'h04;
  localparam logic [7:0] ADR_LINK_TO     = 8'h08;
  localparam logic [7:0] ADR_MIN_REC     = 8'h0c;
  localparam logic [7:0] ADR_SEND_PER    = 8'h10;
  localparam logic [7:0] ADR_DIST_THR    = 8'h14;
  localparam logic [7:0] ADR_ANG_THR     = 8'h18;
  localparam logic [7:0] ADR_STATUS      = 8'h1c;
  localparam logic [7:0] ADR_ODO         = 8'h20;
  localparam logic [7:0] ADR_IRQ_STAT    = 8'h24;
  localparam logic [7:0] ADR_IRQ_EN      = 8'h28;
  localparam logic [7:0] ADR_IRQ_CLR     = 8'h2c;
  // ==========================================================
  // fields
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam int unsigned CTRL_DEEP_BIT  = 1;
  localparam int unsigned IRQ_SLEEP_BIT  = 0;
  localparam int unsigned IRQ_DEEP_BIT   = 1;
  localparam int unsigned IRQ_WAKE_BIT   = 2;
  localparam int unsigned IRQ_REC_BIT    = 3;
  localparam int unsigned IRQ_W          = 4;
  // ==========================================================
  // reset values
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam logic [15:0] SLEEP_TO_RST   = 16'h003c;
  localparam logic [15:0] LINK_TO_RST    = 16'h003c;
  localparam logic [15:0] MIN_REC_RST    = 16'h003c;
  localparam logic [15:0] SEND_PER_RST   = 16'h0078;
  localparam logic [15:0] DIST_THR_RST   = 16'h0000;
  localparam logic [15:0] ANG_THR_RST    = 16'h0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    TSC_AWAKE,
    TSC_SLEEP,
    TSC_DEEP
  } tsc_mode_t;

  typedef struct packed {
    logic [1:0]  ctrl;
    logic [15:0] sleep_to;
    logic [15:0] link_to;
    logic [15:0] min_rec;
    logic [15:0] send_per;
    logic [15:0] dist_thr;
    logic [15:0] ang_thr;
  } tsc_cfg_t;

  typedef struct packed {
    logic [31:0] distance;
    logic        reduced;
    logic        hold_coord;
    logic        periodic;
    logic [2:0]  cause;
  } tsc_rec_t;
endpackage : tsc_pkg

// ===== testbench/tsc_vehicle_model.sv
`timescale 1ns/10ps
// ==========================================
// vehicle side: ignition line, motion sensor, usb host
module tsc_vehicle_model (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  output logic            ignition_input,
  output logic            motion_in,
  output logic            usb_attached
);
  initial {usb_attached, ignition_input, motion_in} = 3'h0;
  // bit 1 of want is the ignition, wired to the first digital input
  always @(posedge clk) {usb_attached, ignition_input, motion_in} <= want;
endmodule : tsc_vehicle_model

// ===== testbench/tsc_top_bench.sv
`timescale 1ns/10ps
module tsc_top_bench;
  logic               clk, rst_n, wr_en, rd_en, time_synced, gps_fix, event_in, irq, record_strobe;
  logic               modem_activity, boot_mode, fw_flashing, device_working, ign, mot, usb;
  logic               gps_power, gps_sleep, modem_power, nav_led, stat_led, prev;
  logic [2:0]         want;
  logic [7:0]         addr;
  logic [15:0]        step_distance, heading_change, step;
  logic [31:0]        wr_data, rd_data, d;
  tsc_pkg::tsc_mode_t mode;
  tsc_pkg::tsc_rec_t  record_info;
  int                 error_cnt, total_checks, cyc, seed, nl, sl, sr, k;
  logic [7:0]         ra [6] = '{tsc_pkg::ADR_CTRL, tsc_pkg::ADR_SLEEP_TO, tsc_pkg::ADR_LINK_TO,
                                 tsc_pkg::ADR_MIN_REC, tsc_pkg::ADR_SEND_PER, 8'h3c};
  logic [31:0]        rv [6] = '{32'h0, 32'h3c, 32'h3c, 32'h3c, 32'h78, 32'h0};

  tsc_vehicle_model u_tsc_vehicle_model (.clk(clk), .want(want), .ignition_input(ign), .motion_in(mot),
    .usb_attached(usb));
  tsc_top #(.SUB_DIV(4)) u_tsc_top (.clk(clk), .rst_n(rst_n), .ignition_input(ign), .motion_in(mot),
    .usb_attached(usb), .time_synced(time_synced), .gps_fix(gps_fix), .step_distance(step_distance),
    .heading_change(heading_change), .event_in(event_in), .modem_activity(modem_activity),
    .boot_mode(boot_mode), .fw_flashing(fw_flashing), .device_working(device_working), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .gps_power(gps_power),
    .gps_sleep(gps_sleep), .modem_power(modem_power), .nav_led(nav_led), .stat_led(stat_led), .mode(mode),
    .record_strobe(record_strobe), .record_info(record_info));

  // ==========================================
  // clock, timeout
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
  task automatic set_want(input logic [2:0] w);
    @(posedge clk);
    want <= w;
  endtask : set_want
  task automatic pulse_ev();
    @(posedge clk);
    event_in <= 1'b1;
    @(posedge clk);
    event_in <= 1'b0;
  endtask : pulse_ev
  task automatic wait_mode(input tsc_pkg::tsc_mode_t m, input int n);
    k = 0;
    while (mode !== m && k < n) begin
      @(negedge clk);
      k++;
    end
    check(32'(mode), 32'(m), "mode");
  endtask : wait_mode
  task automatic wait_rec(input int n);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (record_strobe !== 1'b1 && k < n);
    check(32'(record_strobe), 32'h1, "record strobe");
  endtask : wait_rec
  task automatic watch(input int n);
    nl = 0;
    sl = 0;
    sr = 0;
    prev = 1'b0;
    @(posedge clk);
    repeat (n) begin
      @(negedge clk);
      nl += int'(nav_led);
      sl += int'(stat_led);
      if (stat_led && !prev) sr++;
      prev = stat_led;
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // main sequence
  initial begin
    seed = 17299;
    {rst_n, wr_en, rd_en, time_synced, gps_fix, event_in, modem_activity, boot_mode, fw_flashing} = '0;
    device_working = 1'b1;
    {want, addr, wr_data, step_distance, heading_change} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'h3c, 32'hffffffff);
    foreach (ra[i]) begin
      rd(ra[i]);
      check(d, rv[i], "reset value");
    end
    check(32'(gps_power), 32'h1, "gps power after reset");
    $display("test reset values done");
    watch(40);
    check(32'(nl), 32'd40, "nav lit without fix");
    check(32'(sl), 32'd4, "status 1 s blink");
    @(posedge clk);
    gps_fix <= 1'b1;
    device_working <= 1'b0;
    watch(40);
    check(32'(nl), 32'd4, "nav blink with fix");
    check(32'(sl), 32'd0, "status dark halted");
    @(posedge clk);
    device_working <= 1'b1;
    fw_flashing <= 1'b1;
    watch(40);
    check(32'(sl), 32'd0, "status dark flashing");
    @(posedge clk);
    fw_flashing <= 1'b0;
    boot_mode <= 1'b1;
    watch(40);
    check(32'(sr >= 4), 32'h1, "boot fast blink");
    @(posedge clk);
    boot_mode <= 1'b0;
    modem_activity <= 1'b1;
    @(posedge clk);
    modem_activity <= 1'b0;
    watch(24);
    check(32'(sr >= 2), 32'h1, "modem burst blink");
    $display("test leds done");
    wr(tsc_pkg::ADR_SLEEP_TO, 32'h2);
    wr(tsc_pkg::ADR_IRQ_EN, 32'h5);
    wr(tsc_pkg::ADR_CTRL, 32'h1);
    repeat (100) @(negedge clk);
    check(32'(mode), 32'(tsc_pkg::TSC_AWAKE), "no sleep unsynced");
    @(posedge clk);
    want <= 3'h4;
    repeat (4) @(posedge clk);
    time_synced <= 1'b1;
    repeat (4) @(posedge clk);
    want <= 3'h0;
    repeat (40) @(negedge clk);
    check(32'(mode), 32'(tsc_pkg::TSC_AWAKE), "timeout not yet run");
    wait_mode(tsc_pkg::TSC_SLEEP, 120);
    repeat (2) @(negedge clk);
    check(32'(gps_power), 32'h0, "gps off in sleep");
    check(32'(irq), 32'h1, "sleep irq");
    for (int i = 0; i < 3; i++) begin
      wr(tsc_pkg::ADR_IRQ_CLR, 32'hf);
      set_want(3'(1 << i));
      wait_mode(tsc_pkg::TSC_AWAKE, 8);
      rd(tsc_pkg::ADR_STATUS);
      check(32'(d[31:16]), 32'h0, "stop time cleared");
      check(32'(irq), 32'h1, "wake irq");
      wr(tsc_pkg::ADR_IRQ_CLR, 32'hf);
      repeat (2) @(negedge clk);
      check(32'(irq), 32'h0, "irq cleared");
      set_want(3'h0);
      wait_mode(tsc_pkg::TSC_SLEEP, 140);
    end
    wr(tsc_pkg::ADR_IRQ_EN, 32'h0);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0, "irq masked");
    pulse_ev();
    wait_rec(4);
    check(32'(record_info.hold_coord), 32'h1, "sleep event coord");
    check(32'(record_info.periodic), 32'h0, "sleep event kind");
    $display("test sleep done");
    set_want(3'h1);
    wait_mode(tsc_pkg::TSC_AWAKE, 8);
    wr(tsc_pkg::ADR_LINK_TO, 32'h2);
    wr(tsc_pkg::ADR_MIN_REC, 32'h4);
    wr(tsc_pkg::ADR_SEND_PER, 32'ha);
    wr(tsc_pkg::ADR_CTRL, 32'h3);
    set_want(3'h0);
    wait_mode(tsc_pkg::TSC_SLEEP, 140);
    set_want(3'h1);
    wait_mode(tsc_pkg::TSC_AWAKE, 8);
    wr(tsc_pkg::ADR_MIN_REC, 32'h5);
    set_want(3'h0);
    wait_mode(tsc_pkg::TSC_DEEP, 140);
    repeat (2) @(negedge clk);
    check(32'(gps_sleep), 32'h1, "receiver asleep");
    check(32'(modem_power), 32'h0, "modem off");
    check(32'(nav_led), 32'h0, "nav dark deep");
    watch(80);
    check(32'(sl), 32'd4, "status 2 s blink");
    wait_rec(220);
    check(32'(record_info.reduced), 32'h1, "reduced record");
    check(32'(record_info.cause[0]), 32'h1, "time record");
    repeat (2) @(negedge clk);
    check(32'(modem_power), 32'h1, "modem on to send");
    set_want(3'h2);
    wait_mode(tsc_pkg::TSC_AWAKE, 8);
    $display("test deep sleep done");
    wr(tsc_pkg::ADR_CTRL, 32'h0);
    wr(tsc_pkg::ADR_MIN_REC, 32'hffff);
    for (int i = 0; i < 3; i++) begin
      set_want(3'h1);
      step = {8'h00, 8'($random(seed))} + 16'h1;
      @(posedge clk);
      step_distance <= step;
      heading_change <= 16'($random(seed));
      pulse_ev();
      wait_rec(4);
      repeat (120) @(posedge clk);
      set_want(3'h0);
      repeat (4) @(posedge clk);
      pulse_ev();
      wait_rec(4);
      check(record_info.distance % 32'(step), 32'h0, "distance sum");
      check(32'(record_info.distance >= 32'(step) * 2), 32'h1, "distance seconds");
      check(32'(record_info.hold_coord), 32'h0, "fresh coord");
      rd(tsc_pkg::ADR_ODO);
      check(d, 32'h0, "accumulator cleared");
    end
    set_want(3'h1);
    wr(tsc_pkg::ADR_DIST_THR, 32'(step) * 3);
    wait_rec(200);
    check(32'(record_info.cause[1]), 32'h1, "distance record");
    wr(tsc_pkg::ADR_DIST_THR, 32'h0);
    wr(tsc_pkg::ADR_ANG_THR, 32'h40);
    @(posedge clk);
    heading_change <= 16'h0040;
    wait_rec(60);
    check(32'(record_info.cause[2]), 32'h1, "heading record");
    @(posedge clk);
    gps_fix <= 1'b0;
    pulse_ev();
    wait_rec(4);
    check(32'(record_info.hold_coord), 32'h1, "no fix coord");
    $display("test records done");
    tally_and_finish();
  end
endmodule : tsc_top_bench
